// file: hw/dpc_pkg.sv
// Package with register map, field layout and carrier types of a DMA pair.
package dpc_pkg;

  // ------------------------------------------------------------------
  // Register indices per pair; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [3:0][9:0] DPC_CTL_IDX  = {10'h188, 10'h170, 10'h158, 10'h140};
  localparam logic [3:0][9:0] DPC_TRCL_IDX = {10'h18a, 10'h172, 10'h15a, 10'h142};
  localparam logic [3:0][9:0] DPC_TRAH_IDX = {10'h18c, 10'h174, 10'h15c, 10'h144};
  localparam logic [3:0][9:0] DPC_STAT_IDX = {10'h192, 10'h17a, 10'h162, 10'h14a};
  localparam logic [3:0][9:0] DPC_CBD_IDX  = {10'h194, 10'h17c, 10'h164, 10'h14c};

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int          DPC_EVT_LSB    = 8;
  localparam int          DPC_TRB_LSB    = 4;
  localparam int          DPC_CTBD_LSB   = 0;
  localparam int          DPC_CRBD_LSB   = 8;
  localparam logic [15:0] DPC_CTL_RST    = 16'h0000;
  localparam logic [15:0] DPC_TRCL_RST   = 16'h0000;
  localparam logic [3:0]  DPC_TRAH_RST   = 4'h0;
  localparam logic [1:0]  DPC_PRIO_RSVD  = 2'h3;
  localparam int          DPC_FIRST_SEL  = 2;
  localparam int          DPC_DESC_BYTES = 8;

  // Sticky event flags, same order as their enables in the control word.
  typedef struct packed {
    logic tx_packet_end;
    logic tx_no_buffer;
    logic tx_buffer_end;
    logic rx_packet_end;
    logic rx_no_buffer;
    logic rx_buffer_end;
  } dpc_evt_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    dpc_evt_t   irq_en;
    logic       tx_keep_ownership;
    logic       rx_keep_ownership;
    logic [1:0] priority_code;
    logic       forced_poll;
    logic       request_source_select;
    logic       tx_channel_run;
    logic       rx_channel_run;
  } dpc_ctl_t;

  // Buffer events reported by the pair's data mover.
  typedef struct packed {
    logic tx_buf_done;
    logic tx_buf_last;
    logic tx_desc_buffer_end_enable;
    logic tx_no_buf;
    logic rx_buf_done;
    logic rx_buf_last;
    logic rx_desc_buffer_end_enable;
    logic rx_no_buf;
  } dpc_core_ev_t;

  typedef enum logic [2:0] {
    DPC_TX_IDLE = 3'b001,
    DPC_TX_MOVE = 3'b010,
    DPC_TX_WAIT = 3'b100
  } dpc_tx_st_t;

endpackage

// file: hw/dpc_pair.sv
// Control and transmit-ring setup of one descriptor DMA channel pair.
//
// Notes on behaviour
// - Transmit end-of-packet interrupt only when its enable bit 13 is set.
// - Transmit packet-end events wait for the peripheral's sent indication.
// - Bit 12 enables interrupt on missing buffer during transmission.
// - Bit 11 plus descriptor buffer-end flag give transmit buffer-end interrupt.
// - Bit 10 enables interrupt after the final received packet byte.
// - Bit 9 enables interrupt on missing buffer before or during reception.
// - Bit 8 plus descriptor buffer-end flag give receive buffer-end interrupt.
// - Finished transmit buffer loses ownership unless bit 7 is set.
// - Finished receive buffer loses ownership unless bit 6 is set.
// - Two-bit priority: 00 low, 01 medium, 10 high, 11 reserved.
// - Writing 1 to bit 3 forces one ownership poll; reads 0. Here the poll only happens while a channel runs.
// - On pairs 2 and 3, bit 2 selects HDLC (0) or USB (1).
// - Bit 1 starts or stops transmit; restarting a running channel is ignored.
// - Bit 0 starts or stops receive; restarting a running channel is ignored.
// - Clearing a run bit is ignored while that channel has a pending request.
// - An event interrupts only when its control enable bit is set.
// - Ring word bits 15..4 give base address bits 15..4; low bits zero.
// - Three-bit ring code gives two to the code descriptors, 1 to 128.
// - Pairs 0, 1 serve HDLC A, B; pairs 2, 3 HDLC B, C or USB.
// - Event flags are sticky until software clears them.
// - Ring base bits 19..16 sit in a separate high word.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps

module dpc_pair
  import dpc_pkg::*;
#(
  parameter int PAIR       = 0,              // Pair number 0 to 3.
  parameter int DESC_BYTES = DPC_DESC_BYTES  // Descriptor size in bytes.
)
(
  input  wire logic         clk,             // System clock.
  input  wire logic         reset,           // Synchronous reset, high.
  input  wire logic         wb_cyc_i,        // Wishbone cycle.
  input  wire logic         wb_stb_i,        // Wishbone strobe.
  input  wire logic         wb_we_i,         // Wishbone write.
  input  wire logic [11:0]  wb_adr_i,        // Wishbone byte address.
  input  wire logic [3:0]   wb_sel_i,        // Wishbone byte lanes.
  input  wire logic [31:0]  wb_dat_i,        // Wishbone write data.
  output logic      [31:0]  wb_dat_o,        // Wishbone read data.
  output logic              wb_ack_o,        // Wishbone acknowledge.
  input  wire logic         periph_tx_req,   // Peripheral transmit request.
  input  wire logic         periph_rx_req,   // Peripheral receive request.
  input  wire logic         periph_tx_sent,  // Packet left the peripheral.
  input  wire dpc_core_ev_t core_ev,         // Data mover buffer events.
  output logic              tx_run,          // Transmit channel running.
  output logic              rx_run,          // Receive channel running.
  output logic              own_poll,        // Poll ownership, pulse.
  output logic              tx_own_clear,    // Clear tx ownership, pulse.
  output logic              rx_own_clear,    // Clear rx ownership, pulse.
  output logic      [19:0]  tx_desc_addr,    // Current tx descriptor address.
  output logic      [1:0]   pair_priority,   // Arbitration rank.
  output logic              serve_usb,       // Requests come from USB.
  output logic              irq_req          // Enabled event pending.
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  localparam logic [9:0]  IDX_CTL  = DPC_CTL_IDX[PAIR];
  localparam logic [9:0]  IDX_TRCL = DPC_TRCL_IDX[PAIR];
  localparam logic [9:0]  IDX_TRAH = DPC_TRAH_IDX[PAIR];
  localparam logic [9:0]  IDX_STAT = DPC_STAT_IDX[PAIR];
  localparam logic [9:0]  IDX_CBD  = DPC_CBD_IDX[PAIR];
  localparam logic        HAS_SEL  = (PAIR >= DPC_FIRST_SEL);
  localparam logic [19:0] DESC_SZ  = 20'(DESC_BYTES);

  // Merges the enabled byte lanes of a write into the old 16-bit value.
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  logic [9:0]   word_idx;
  logic         req;
  logic         wr;
  logic         wr_ctl;
  logic         wr_trcl;
  logic         wr_trah;
  logic         wr_stat;
  logic         wr_cbd;
  dpc_ctl_t     ctl_q;
  dpc_ctl_t     ctl_w;
  dpc_evt_t     flags_q;
  dpc_evt_t     flag_set;
  dpc_evt_t     flag_keep;
  logic [15:0]  trcl_q;
  logic [3:0]   trah_q;
  logic [6:0]   tx_idx_q;
  logic [6:0]   rx_idx_q;
  logic [6:0]   tx_last_idx;
  dpc_tx_st_t   tx_st_q;
  logic         ttc_wait_q;
  logic [15:0]  rd_val;
  logic         ack_q;
  logic [31:0]  dat_q;

  assign word_idx = wb_adr_i[11:2];
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i;
  assign wr_ctl   = wr & (word_idx == IDX_CTL);
  assign wr_trcl  = wr & (word_idx == IDX_TRCL);
  assign wr_trah  = wr & (word_idx == IDX_TRAH);
  assign wr_stat  = wr & (word_idx == IDX_STAT);
  assign wr_cbd   = wr & (word_idx == IDX_CBD);
  assign ctl_w    = dpc_ctl_t'(lane_merge(16'(ctl_q), wb_dat_i, wb_sel_i));

  // ------------------------------------------------------------------
  // Control word
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl_q <= dpc_ctl_t'(DPC_CTL_RST);
    end
    else if (wr_ctl)
    begin
      ctl_q.irq_en            <= ctl_w.irq_en;
      ctl_q.tx_keep_ownership <= ctl_w.tx_keep_ownership;
      ctl_q.rx_keep_ownership <= ctl_w.rx_keep_ownership;
      // The reserved code is refused so the arbiter never sees it.
      if (ctl_w.priority_code != DPC_PRIO_RSVD)
      begin
        ctl_q.priority_code <= ctl_w.priority_code;
      end
      // Pairs 0 and 1 have no source choice; the bit reads as zero.
      ctl_q.request_source_select <= HAS_SEL &
                                     ctl_w.request_source_select;
      // A stop is ignored while the peripheral still has a request up.
      if (ctl_w.tx_channel_run | ~periph_tx_req)
      begin
        ctl_q.tx_channel_run <= ctl_w.tx_channel_run;
      end
      if (ctl_w.rx_channel_run | ~periph_rx_req)
      begin
        ctl_q.rx_channel_run <= ctl_w.rx_channel_run;
      end
    end
  end

  // Forced poll: a start from stopped also polls once, so a fresh ring
  // is noticed without a separate write.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      own_poll <= 1'b0;
    end
    else
    begin
      own_poll <= wr_ctl & ((ctl_w.forced_poll &
                             (ctl_q.tx_channel_run | ctl_q.rx_channel_run)) |
                            (ctl_w.tx_channel_run & ~ctl_q.tx_channel_run) |
                            (ctl_w.rx_channel_run &
                             ~ctl_q.rx_channel_run));
    end
  end

  // ------------------------------------------------------------------
  // Transmit ring setup
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trcl_q <= DPC_TRCL_RST;
      trah_q <= DPC_TRAH_RST;
    end
    else
    begin
      if (wr_trcl)
      begin
        trcl_q <= lane_merge(trcl_q, wb_dat_i, wb_sel_i) &
                  16'hfff7;
      end
      if (wr_trah)
      begin
        trah_q <= wb_sel_i[0] ? wb_dat_i[3:0] :
                  trah_q;
      end
    end
  end

  // Last valid entry is two to the code, minus one.
  assign tx_last_idx = 7'((8'h01 << trcl_q[2:0]) - 8'h01);

  // ------------------------------------------------------------------
  // Descriptor indices
  // ------------------------------------------------------------------
  // Receive ring size lives outside this block, so its index wraps at
  // the field width; software reloads it through the register while receive is stopped.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_idx_q <= 7'h00;
      rx_idx_q <= 7'h00;
    end
    else
    begin
      if (wr_cbd & ~ctl_q.tx_channel_run & wb_sel_i[0])
      begin
        tx_idx_q <= wb_dat_i[DPC_CTBD_LSB +: 7];
      end
      else if (core_ev.tx_buf_done & ctl_q.tx_channel_run)
      begin
        tx_idx_q <= (tx_idx_q >= tx_last_idx) ? 7'h00 :
                    tx_idx_q + 7'h01;
      end
      if (wr_cbd & ~ctl_q.rx_channel_run & wb_sel_i[1])
      begin
        rx_idx_q <= wb_dat_i[DPC_CRBD_LSB +: 7];
      end
      else if (core_ev.rx_buf_done & ctl_q.rx_channel_run)
      begin
        rx_idx_q <= rx_idx_q + 7'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit packet sequencing
  // ------------------------------------------------------------------
  // A packet's last buffer parks here until the peripheral reports the
  // frame as sent, so completion events never run ahead of the wire.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_st_q    <= DPC_TX_IDLE;
      ttc_wait_q <= 1'b0;
    end
    else
    begin
      case (tx_st_q)
        DPC_TX_IDLE:
        begin
          if (ctl_q.tx_channel_run)
          begin
            tx_st_q <= DPC_TX_MOVE;
          end
        end
        DPC_TX_MOVE:
        begin
          if (core_ev.tx_buf_done & core_ev.tx_buf_last)
          begin
            tx_st_q    <= DPC_TX_WAIT;
            ttc_wait_q <= core_ev.tx_desc_buffer_end_enable;
          end
          else if (~ctl_q.tx_channel_run)
          begin
            tx_st_q <= DPC_TX_IDLE;
          end
        end
        DPC_TX_WAIT:
        begin
          if (periph_tx_sent)
          begin
            tx_st_q    <= ctl_q.tx_channel_run ? DPC_TX_MOVE :
                                                 DPC_TX_IDLE;
            ttc_wait_q <= 1'b0;
          end
        end
        default:
        begin
          tx_st_q    <= DPC_TX_IDLE;
          ttc_wait_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------------
  always_comb
  begin
    flag_set               = '0;
    flag_set.tx_packet_end = (tx_st_q == DPC_TX_WAIT) &
                             periph_tx_sent;
    flag_set.tx_buffer_end = (((tx_st_q == DPC_TX_MOVE) &
                               core_ev.tx_buf_done &
                               ~core_ev.tx_buf_last &
                               core_ev.tx_desc_buffer_end_enable) |
                              ((tx_st_q == DPC_TX_WAIT) &
                               periph_tx_sent & ttc_wait_q));
    flag_set.tx_no_buffer  = core_ev.tx_no_buf &
                             (tx_st_q != DPC_TX_IDLE);
    flag_set.rx_packet_end = core_ev.rx_buf_done &
                             core_ev.rx_buf_last;
    flag_set.rx_no_buffer  = core_ev.rx_no_buf &
                             ctl_q.rx_channel_run;
    flag_set.rx_buffer_end = core_ev.rx_buf_done &
                             core_ev.rx_desc_buffer_end_enable;
  end

  // Writing 0 clears a flag and 1 leaves it; a new event wins.
  always_comb
  begin
    flag_keep = flags_q;
    if (wr_stat & wb_sel_i[1])
    begin
      flag_keep = flags_q & dpc_evt_t'(wb_dat_i[DPC_EVT_LSB +: 6]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= flag_keep | flag_set;
    end
  end

  // ------------------------------------------------------------------
  // Datapath outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_own_clear  <= 1'b0;
      rx_own_clear  <= 1'b0;
      tx_desc_addr  <= 20'h00000;
      irq_req       <= 1'b0;
      tx_run        <= 1'b0;
      rx_run        <= 1'b0;
      pair_priority <= 2'h0;
      serve_usb     <= 1'b0;
    end
    else
    begin
      tx_own_clear  <= core_ev.tx_buf_done &
                       ~ctl_q.tx_keep_ownership;
      rx_own_clear  <= core_ev.rx_buf_done &
                       ~ctl_q.rx_keep_ownership;
      tx_desc_addr  <= {trah_q, trcl_q[15:DPC_TRB_LSB], 4'h0} +
                       20'(tx_idx_q) * DESC_SZ;
      irq_req       <= |(flags_q & ctl_q.irq_en);
      tx_run        <= ctl_q.tx_channel_run;
      rx_run        <= ctl_q.rx_channel_run;
      pair_priority <= ctl_q.priority_code;
      serve_usb     <= HAS_SEL & ctl_q.request_source_select;
    end
  end

  // ------------------------------------------------------------------
  // Wishbone read and acknowledge
  // ------------------------------------------------------------------
  always_comb
  begin
    rd_val = 16'h0000;
    case (word_idx)
      IDX_CTL:  rd_val = 16'(ctl_q) & 16'hfff7;
      IDX_TRCL: rd_val = trcl_q;
      IDX_TRAH: rd_val = {12'h000, trah_q};
      IDX_STAT: rd_val = {2'h0, flags_q, 8'h00};
      IDX_CBD:  rd_val = {1'b0, rx_idx_q, 1'b0, tx_idx_q};
      default:  rd_val = 16'h0000;
    endcase
  end

  // Every access, mapped or not, is answered one cycle later.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      if (req & ~wb_we_i)
      begin
        dat_q <= {16'h0000, rd_val};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule

// file: verif/dpc_pair_sva.sv
// Checker for the bus, ownership, run and interrupt behaviour of one pair.
`timescale 1ns/1ps
module dpc_pair_sva
  import dpc_pkg::*;
#(
  parameter int PAIR = 0                 // Pair number.
)
(
  input wire logic         clk,            // System clock.
  input wire logic         reset,          // Synchronous reset.
  input wire logic         wb_cyc_i,       // Bus cycle.
  input wire logic         wb_stb_i,       // Bus strobe.
  input wire logic         wb_we_i,        // Bus write.
  input wire logic  [11:0] wb_adr_i,       // Bus address.
  input wire logic  [3:0]  wb_sel_i,       // Byte lanes.
  input wire logic  [31:0] wb_dat_i,       // Write data.
  input wire logic         wb_ack_o,       // Acknowledge.
  input wire logic         periph_tx_req,  // Transmit request.
  input wire dpc_core_ev_t core_ev,        // Mover events.
  input wire logic         tx_run,         // Transmit running.
  input wire logic         own_poll,       // Poll pulse.
  input wire logic         tx_own_clear,   // Tx ownership clear.
  input wire logic         rx_own_clear,   // Rx ownership clear.
  input wire logic  [19:0] tx_desc_addr,   // Tx descriptor address.
  input wire logic  [1:0]  pair_priority,  // Arbitration rank.
  input wire logic         irq_req         // Interrupt request.
);
  // --------------------------------------------------------------
  // Mirror of the control bits that the checks depend on
  // --------------------------------------------------------------
  logic       wr_ctl;
  logic [1:0] keep_q;
  logic [5:0] en_q;
  assign wr_ctl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                  (wb_adr_i[11:2] == DPC_CTL_IDX[PAIR]);
  always_ff @(posedge clk)
  begin
    if (reset)
      keep_q <= 2'h0;
    else if (wr_ctl && wb_sel_i[0])
      keep_q <= wb_dat_i[7:6];
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      en_q <= 6'h00;
    else if (wr_ctl && wb_sel_i[1])
      en_q <= wb_dat_i[13:8];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  AST_TX_OWN: assert property (tx_own_clear ==
    ($past(core_ev.tx_buf_done) && !$past(keep_q[1])))
    else $error("tx ownership clear wrong");
  AST_RX_OWN: assert property (rx_own_clear ==
    ($past(core_ev.rx_buf_done) && !$past(keep_q[0])))
    else $error("rx ownership clear wrong");
  AST_IRQ_GATED: assert property ((en_q == 6'h00) &&
    $past(en_q == 6'h00) |-> !irq_req) else $error("irq with enables off");
  AST_RX_NOBUF_IRQ: assert property (core_ev.rx_no_buf && en_q[1] |->
    ##[1:3] irq_req) else $error("no irq on missing rx buffer");
  AST_POLL_PULSE: assert property (own_poll |=> !own_poll)
    else $error("poll pulse too long");
  AST_PRIO_LEGAL: assert property (pair_priority != DPC_PRIO_RSVD)
    else $error("reserved priority code taken");
  AST_RUN_HOLD: assert property (periph_tx_req [*2] ##0 tx_run |=>
    tx_run) else $error("tx stopped while request pending");
  AST_DESC_ALIGN: assert property (tx_desc_addr[2:0] == 3'h0)
    else $error("descriptor address misaligned");
  COV_WRITE: cover property (wr_ctl ##1 wb_ack_o);
  COV_OWN: cover property (tx_own_clear);
  COV_POLL: cover property (own_poll);
  COV_IRQ: cover property ($rose(irq_req));
endmodule

bind dpc_pair dpc_pair_sva #(.PAIR(PAIR)) u_dpc_pair_sva (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .periph_tx_req(periph_tx_req),
  .core_ev(core_ev), .tx_run(tx_run), .own_poll(own_poll),
  .tx_own_clear(tx_own_clear), .rx_own_clear(rx_own_clear),
  .tx_desc_addr(tx_desc_addr), .pair_priority(pair_priority),
  .irq_req(irq_req));

// file: verif/dpc_periph_model.sv
// Model of the requesting serial peripheral beside a DMA pair.
`timescale 1ns/1ps
module dpc_periph_model
(
  input wire logic       clk,            // System clock.
  input wire logic       reset,          // Synchronous reset.
  input wire logic       tx_want,        // Bench asks for tx request.
  input wire logic       rx_want,        // Bench asks for rx request.
  input wire logic       sent_go,        // Last byte handed over.
  input wire logic [3:0] sent_dly,       // Line time before success.
  output logic           periph_tx_req,  // Transmit request.
  output logic           periph_rx_req,  // Receive request.
  output logic           periph_tx_sent  // Packet went out, pulse.
);
  logic [4:0] cnt_q;
  // The bench withdraws requests before it stops a channel.
  always_ff @(posedge clk)
  begin
    if (reset)
      {periph_tx_req, periph_rx_req} <= 2'b00;
    else
      {periph_tx_req, periph_rx_req} <= {tx_want, rx_want};
  end
  // Success is reported only after the line time has run out.
  always_ff @(posedge clk)
  begin
    periph_tx_sent <= 1'b0;
    if (reset)
      cnt_q <= 5'h00;
    else if (sent_go)
      cnt_q <= {1'b0, sent_dly} + 5'h01;
    else if (cnt_q != 5'h00)
    begin
      cnt_q <= cnt_q - 5'h01;
      periph_tx_sent <= (cnt_q == 5'h01);
    end
  end
endmodule

// file: verif/testbench.sv
// Self-checking bench for pair 2: registers, run control, ring, events.
`timescale 1ns/1ps
module testbench
  import dpc_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d;
    logic [3:0]  s;
    logic [15:0] e;
  } dpc_row_t;
  localparam int          P     = 2;
  localparam logic [11:0] A_CTL = {DPC_CTL_IDX[P], 2'b00};
  localparam logic [11:0] A_TRL = {DPC_TRCL_IDX[P], 2'b00};
  localparam logic [11:0] A_TRH = {DPC_TRAH_IDX[P], 2'b00};
  localparam logic [11:0] A_STA = {DPC_STAT_IDX[P], 2'b00};
  localparam logic [11:0] A_CBD = {DPC_CBD_IDX[P], 2'b00};
  localparam logic [11:0] REGS [5] = '{A_CTL, A_TRL, A_TRH, A_STA, A_CBD};
  localparam dpc_row_t ROWS [10] = '{
    '{A_TRL, 16'hffff, 4'h3, 16'hfff7}, '{A_TRL, 16'h1201, 4'h3, 16'h1201},
    '{A_TRH, 16'hffff, 4'h3, 16'h000f}, '{A_TRH, 16'h0005, 4'h3, 16'h0005},
    '{A_CTL, 16'h3fe4, 4'h3, 16'h3fe4}, '{A_CTL, 16'h3ff4, 4'h3, 16'h3fe4},
    '{A_CTL, 16'h3fd4, 4'h3, 16'h3fd4}, '{A_CTL, 16'h00cc, 4'h1, 16'h3fc4},
    '{A_CTL, 16'h0000, 4'h3, 16'h0000}, '{12'h000, 16'h1234, 4'h3, 16'h0000}};
  logic         clk, reset, cyc, stb, we, ack, tx_req, rx_req, sent;
  logic         tx_run, rx_run, own_poll, tx_oc, rx_oc, serve_usb, irq_req;
  logic         tx_want, rx_want, sent_go;
  logic [3:0]   sel, sent_dly;
  logic [11:0]  adr;
  logic [31:0]  dat_i, dat_o;
  logic [19:0]  tx_desc_addr;
  logic [1:0]   prio;
  logic [15:0]  rd;
  dpc_core_ev_t core_ev;
  int           error_cnt, n_checks, poll_n, txoc_n, rxoc_n, k;

  dpc_pair #(.PAIR(P)) u_dpc_pair (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .periph_tx_req(tx_req), .periph_rx_req(rx_req), .periph_tx_sent(sent),
    .core_ev(core_ev), .tx_run(tx_run), .rx_run(rx_run),
    .own_poll(own_poll), .tx_own_clear(tx_oc), .rx_own_clear(rx_oc),
    .tx_desc_addr(tx_desc_addr), .pair_priority(prio),
    .serve_usb(serve_usb), .irq_req(irq_req));
  dpc_periph_model u_dpc_periph_model (.clk(clk), .reset(reset),
    .tx_want(tx_want), .rx_want(rx_want), .sent_go(sent_go),
    .sent_dly(sent_dly), .periph_tx_req(tx_req), .periph_rx_req(rx_req),
    .periph_tx_sent(sent));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Holds the request until ack is sampled; never assumes a latency.
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, s};
    adr <= a;
    dat_i <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1)
      error_cnt++;
    rd = dat_o[15:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000, 4'h3);
    chk(rd, e);
  endtask
  task automatic ev(input logic [7:0] e);
    @(posedge clk);
    core_ev <= dpc_core_ev_t'(e);
    @(posedge clk);
    core_ev <= '0;
    repeat (5) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    if (own_poll === 1'b1)
      poll_n++;
    if (tx_oc === 1'b1)
      txoc_n++;
    if (rx_oc === 1'b1)
      rxoc_n++;
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    {reset, cyc, stb, we, tx_want, rx_want, sent_go} = 7'b1000000;
    {adr, sel, dat_i, core_ev, sent_dly} = '0;
    {error_cnt, n_checks, poll_n, txoc_n, rxoc_n} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({tx_run, rx_run, own_poll, serve_usb, irq_req, prio}, 32'h0);
    foreach (REGS[i]) rdchk(REGS[i], 16'h0000);
    foreach (ROWS[i])
    begin
      wb(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].s);
      rdchk(ROWS[i].a, ROWS[i].e);
    end
    wb(1'b1, A_CTL, 16'h0003, 4'h3);
    repeat (3) @(posedge clk);
    chk({tx_run, rx_run}, 2'b11);
    chk(tx_desc_addr, 20'h51200);
    ev(8'h80);
    chk(tx_desc_addr, 20'h51208);
    ev(8'h80);
    chk(tx_desc_addr, 20'h51200);
    ev(8'h08);
    chk({txoc_n[15:0], rxoc_n[15:0]}, 32'h00020001);
    wb(1'b1, A_CTL, 16'h00c3, 4'h3);
    ev(8'h88);
    chk({txoc_n[15:0], rxoc_n[15:0]}, 32'h00020001);
    k = poll_n;
    wb(1'b1, A_CTL, 16'h00c3, 4'h3);
    repeat (5) @(posedge clk);
    chk(poll_n, k);
    wb(1'b1, A_CTL, 16'h00cb, 4'h3);
    repeat (5) @(posedge clk);
    chk(poll_n, k + 1);
    {tx_want, rx_want} <= 2'b11;
    repeat (4) @(posedge clk);
    wb(1'b1, A_CTL, 16'h0000, 4'h3);
    repeat (3) @(posedge clk);
    chk({tx_run, rx_run}, 2'b11);
    {tx_want, rx_want} <= 2'b00;
    repeat (4) @(posedge clk);
    wb(1'b1, A_CTL, 16'h0000, 4'h3);
    repeat (3) @(posedge clk);
    chk({tx_run, rx_run}, 2'b00);
    wb(1'b1, A_CBD, 16'h0500, 4'h3);
    rdchk(A_CBD, 16'h0500);
    chk(tx_desc_addr, 20'h51200);
    wb(1'b1, A_CTL, 16'h0207, 4'h3);
    repeat (3) @(posedge clk);
    chk(serve_usb, 1'b1);
    ev(8'h1f);
    rdchk(A_STA, 16'h1700);
    chk(irq_req, 1'b1);
    wb(1'b1, A_CTL, 16'h0023, 4'h3);
    repeat (3) @(posedge clk);
    chk({irq_req, serve_usb, prio}, 4'h2);
    wb(1'b1, A_STA, 16'h0000, 4'h3);
    rdchk(A_STA, 16'h0000);
    wb(1'b1, A_CTL, 16'h3fc3, 4'h3);
    ev(8'h80);
    rdchk(A_STA, 16'h0000);
    ev(8'he0);
    rdchk(A_STA, 16'h0000);
    chk(irq_req, 1'b0);
    sent_dly <= 4'h6;
    sent_go <= 1'b1;
    @(posedge clk);
    sent_go <= 1'b0;
    repeat (12) @(posedge clk);
    rdchk(A_STA, 16'h2800);
    chk(irq_req, 1'b1);
    print_verdict();
  end
endmodule
